// ### hdl/pic_pkg.sv
// Constants and types shared by the interrupt controller files
package pic_pkg;
  localparam int          NUM_SRC        = 11;
  localparam int          SRC_W          = 4;
  localparam logic [15:0] VEC_RESET      = 16'hFFFE;
  localparam logic [15:0] VEC_TOP        = 16'hFFFC;
  localparam logic [15:0] VEC_STEP       = 16'h0002;
  localparam logic [15:0] VEC_LAST       = 16'hFFE8;
  // Source indexes, priority order (0 highest)
  localparam logic [3:0]  SRC_KEY        = 4'h0;
  localparam logic [3:0]  SRC_BIT        = 4'h1;
  localparam logic [3:0]  SRC_EXT0       = 4'h2;
  localparam logic [3:0]  SRC_EXT1       = 4'h3;
  localparam logic [3:0]  SRC_TMR0       = 4'h4;
  localparam logic [3:0]  SRC_TMR1       = 4'h5;
  localparam logic [3:0]  SRC_EXT2       = 4'h6;
  localparam logic [3:0]  SRC_REM        = 4'h7;
  localparam logic [3:0]  SRC_ADC        = 4'h8;
  localparam logic [3:0]  SRC_SIO        = 4'h9;
  localparam logic [3:0]  SRC_WT         = 4'hA;
  // Register offsets on the plain port
  localparam logic [2:0]  ADR_IEN_HIGH   = 3'h0;
  localparam logic [2:0]  ADR_IEN_LOW    = 3'h1;
  localparam logic [2:0]  ADR_IRQ_HIGH   = 3'h2;
  localparam logic [2:0]  ADR_IRQ_LOW    = 3'h3;
  localparam logic [2:0]  ADR_EDGE_SEL   = 3'h4;
  localparam logic [2:0]  ADR_PSW        = 3'h5;
  localparam logic [2:0]  ADR_EV_STATUS  = 3'h6;
  localparam logic [2:0]  ADR_EV_ENABLE  = 3'h7;
  localparam logic [2:0]  ADR_EV_CLEAR   = 3'h6;
  localparam int          PSW_IFLAG_BIT  = 2;
  localparam logic [7:0]  PSW_RESET      = 8'h00;
  // Edge select codes, two bits per pin
  localparam logic [1:0]  EDGE_NONE      = 2'h0;
  localparam logic [1:0]  EDGE_FALL      = 2'h1;
  localparam logic [1:0]  EDGE_RISE      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;
  // Acceptance latency in oscillator periods
  localparam int          ACCEPT_PERIODS = 8;
  localparam logic [3:0]  ACCEPT_CYCLES  = 4'(ACCEPT_PERIODS);
  // Event status bits
  localparam int          EV_ACCEPT      = 0;
  localparam int          EV_EXT         = 1;
  localparam int          EV_W           = 2;
  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_WAIT = 2'b01,
    PIC_REQ  = 2'b11
  } pic_state_t;
endpackage

// ### hdl/pic_regmem.sv
// Small register-read memory with registered read data
`timescale 1ns/1ps
module pic_regmem (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] word_i [8],
  input  wire logic [2:0] addr_i,
  output logic      [7:0] data_o
);
  // Read data captured one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_o <= 8'h00;
    else if (rd_i)
      data_o <= word_i[addr_i];
    else
      data_o <= 8'h00;
  end
endmodule

// ### hdl/pic_top.sv
// Prioritized interrupt controller top
//
// Function
// - Sources rank key scan first down to watch timer last, vectors FFFC..FFE8, reset FFFE.
// - External flags sit in the high request register and clear when vectored.
// - Timer 0 and 1 flags set on a timer match event.
// - Converter flag sets when a conversion finishes.
// - Interval timer flag sets on counter overflow.
// - Each external pin requests on falling, rising or both edges.
// - Bit 2 of the status word gates all maskable sources.
// - A source whose enable is 0 is never accepted.
// - Acceptance clears the master enable; the core pushes and vectors.
// - Software reads and writes every request flag.
// - A flag holds until accepted or cleared by reset or software.
// - Highest priority pending enabled request is served first.
// - Acceptance takes 8 periods after the instruction ends.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module pic_top (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic [2:0]  REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [7:0]  REG_RDATA_O,
  input  wire logic        KEY_EV_I,
  input  wire logic        BIT_OVF_I,
  input  wire logic [2:0]  EXT_PIN_I,
  input  wire logic        TMR0_MATCH_I,
  input  wire logic        TMR1_MATCH_I,
  input  wire logic        REM_EV_I,
  input  wire logic        ADC_DONE_I,
  input  wire logic        SIO_DONE_I,
  input  wire logic        WT_EV_I,
  input  wire logic        INSTR_DONE_I,
  input  wire logic        CORE_ACK_I,
  output logic             CORE_REQ_O,
  output logic      [15:0] CORE_VEC_O,
  output logic             PSW_IFLAG_O,
  output logic             IRQ_O
);
  localparam int EV_W_L = pic_pkg::EV_W;
  logic [10:0]              irq_req;
  logic [10:0]              irq_en;
  logic [5:0]               ext_edge_select_reg;
  logic [7:0]               processor_status_word;
  logic [2:0]               ext_prev;
  logic [2:0]               ext_hit;
  logic [10:0]              src_ev;
  logic [10:0]              ack_clr;
  logic [10:0]              live;
  logic                     any_live;
  logic [3:0]               win;
  logic [3:0]               sel;
  logic [3:0]               wait_cnt;
  logic [EV_W_L-1:0]        ev_status;
  logic [EV_W_L-1:0]        ev_enable;
  logic [EV_W_L-1:0]        ev_set;
  logic [7:0]               rd_words [8];
  pic_pkg::pic_state_t      state;
  pic_pkg::pic_state_t      next_state;

  // Register views of the request and enable bits
  logic [7:0] irq_request_high_reg;
  logic [7:0] irq_request_low_reg;
  logic [7:0] irq_enable_high_reg;
  logic [7:0] irq_enable_low_reg;
  assign irq_request_high_reg = {irq_req[7:0]};
  assign irq_request_low_reg  = {5'h00, irq_req[10:8]};
  assign irq_enable_high_reg  = {irq_en[7:0]};
  assign irq_enable_low_reg   = {5'h00, irq_en[10:8]};

  // Edge test for one external pin, chosen per pin
  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic       prev,
                                    input logic       cur);
    logic fall;
    logic rise;
    fall = prev & ~cur;
    rise = ~prev & cur;
    case (mode)
      pic_pkg::EDGE_FALL: edge_hit = fall;
      pic_pkg::EDGE_RISE: edge_hit = rise;
      pic_pkg::EDGE_BOTH: edge_hit = fall | rise;
      default:            edge_hit = 1'b0;
    endcase
  endfunction

  // Vector for a source index, stepping down from the top slot
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    vec_of = 16'(pic_pkg::VEC_TOP - pic_pkg::VEC_STEP * 16'(idx));
  endfunction

  // Pin history; pins are synchronous to the clock
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      ext_prev <= 3'h0;
    else
      ext_prev <= EXT_PIN_I;
  end

  // Edge detection per pin
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      ext_hit[i] = edge_hit(ext_edge_select_reg[2*i +: 2], ext_prev[i],
                            EXT_PIN_I[i]);
  end

  // Source events mapped to priority slots
  always_comb
  begin
    src_ev                    = '0;
    src_ev[pic_pkg::SRC_KEY]  = KEY_EV_I;
    src_ev[pic_pkg::SRC_BIT]  = BIT_OVF_I;
    src_ev[pic_pkg::SRC_EXT0] = ext_hit[0];
    src_ev[pic_pkg::SRC_EXT1] = ext_hit[1];
    src_ev[pic_pkg::SRC_TMR0] = TMR0_MATCH_I;
    src_ev[pic_pkg::SRC_TMR1] = TMR1_MATCH_I;
    src_ev[pic_pkg::SRC_EXT2] = ext_hit[2];
    src_ev[pic_pkg::SRC_REM]  = REM_EV_I;
    src_ev[pic_pkg::SRC_ADC]  = ADC_DONE_I;
    src_ev[pic_pkg::SRC_SIO]  = SIO_DONE_I;
    src_ev[pic_pkg::SRC_WT]   = WT_EV_I;
  end

  // Flag cleared by the core acknowledge of the presented source
  always_comb
  begin
    ack_clr = '0;
    if (state == pic_pkg::PIC_REQ && CORE_ACK_I)
      ack_clr[sel] = 1'b1;
  end

  // Request flags: software write, ack clear, then event set wins
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      irq_req <= '0;
    else
    begin
      for (int i = 0; i < pic_pkg::NUM_SRC; i++)
      begin
        if (src_ev[i])
          irq_req[i] <= 1'b1;
        else if (ack_clr[i])
          irq_req[i] <= 1'b0;
        else if (REG_WR_I && REG_ADDR_I == pic_pkg::ADR_IRQ_HIGH && i < 8)
          irq_req[i] <= REG_WDATA_I[i];
        else if (REG_WR_I && REG_ADDR_I == pic_pkg::ADR_IRQ_LOW && i >= 8)
          irq_req[i] <= REG_WDATA_I[i-8];
      end
    end
  end

  // Enable and edge-select registers
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      irq_en              <= '0;
      ext_edge_select_reg <= '0;
    end
    else if (REG_WR_I)
    begin
      if (REG_ADDR_I == pic_pkg::ADR_IEN_HIGH)
        irq_en[7:0] <= REG_WDATA_I;
      else if (REG_ADDR_I == pic_pkg::ADR_IEN_LOW)
        irq_en[10:8] <= REG_WDATA_I[2:0];
      else if (REG_ADDR_I == pic_pkg::ADR_EDGE_SEL)
        ext_edge_select_reg <= REG_WDATA_I[5:0];
    end
  end

  // Status word; acceptance drops the master enable over a write
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      processor_status_word <= pic_pkg::PSW_RESET;
    else if (state == pic_pkg::PIC_REQ && CORE_ACK_I)
      processor_status_word[pic_pkg::PSW_IFLAG_BIT] <= 1'b0;
    else if (REG_WR_I && REG_ADDR_I == pic_pkg::ADR_PSW)
      processor_status_word <= REG_WDATA_I;
  end

  // Qualified requests and fixed priority pick
  always_comb
  begin
    live     = irq_req & irq_en;
    any_live = (|live) & processor_status_word[pic_pkg::PSW_IFLAG_BIT];
    win      = 4'h0;
    for (int i = pic_pkg::NUM_SRC - 1; i >= 0; i--)
      if (live[i])
        win = 4'(i);
  end

  // Acceptance sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      pic_pkg::PIC_IDLE:
        if (any_live && INSTR_DONE_I)
          next_state = pic_pkg::PIC_WAIT;
      pic_pkg::PIC_WAIT:
        if (!any_live)
          next_state = pic_pkg::PIC_IDLE;
        else if (wait_cnt == pic_pkg::ACCEPT_CYCLES - 4'h1)
          next_state = pic_pkg::PIC_REQ;
      pic_pkg::PIC_REQ:
        if (CORE_ACK_I)
          next_state = pic_pkg::PIC_IDLE;
      default:
        next_state = pic_pkg::PIC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      state <= pic_pkg::PIC_IDLE;
    else
      state <= next_state;
  end

  // Latency counter for the acceptance window
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I || state != pic_pkg::PIC_WAIT)
      wait_cnt <= 4'h0;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end

  // Winner frozen while presented so the ack hits the right flag
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      sel <= 4'h0;
    else if (state != pic_pkg::PIC_REQ)
      sel <= win;
  end

  // Core outputs, registered
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      CORE_REQ_O <= 1'b0;
      CORE_VEC_O <= pic_pkg::VEC_RESET;
    end
    else
    begin
      CORE_REQ_O <= (next_state == pic_pkg::PIC_REQ) &&
                    !(state == pic_pkg::PIC_REQ && CORE_ACK_I);
      if (next_state == pic_pkg::PIC_REQ && state != pic_pkg::PIC_REQ)
        CORE_VEC_O <= vec_of(win);
    end
  end

  // Event status: acceptance and external edges, set wins over clear
  assign ev_set = {|ext_hit, state == pic_pkg::PIC_REQ && CORE_ACK_I};
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      ev_status <= '0;
      ev_enable <= '0;
    end
    else
    begin
      if (REG_WR_I && REG_ADDR_I == pic_pkg::ADR_EV_CLEAR)
        ev_status <= (ev_status & ~REG_WDATA_I[EV_W_L-1:0]) | ev_set;
      else
        ev_status <= ev_status | ev_set;
      if (REG_WR_I && REG_ADDR_I == pic_pkg::ADR_EV_ENABLE)
        ev_enable <= REG_WDATA_I[EV_W_L-1:0];
    end
  end

  // Level interrupt and status-word mirror
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      IRQ_O       <= 1'b0;
      PSW_IFLAG_O <= 1'b0;
    end
    else
    begin
      IRQ_O       <= |(next_ev_status() & ev_enable);
      PSW_IFLAG_O <= processor_status_word[pic_pkg::PSW_IFLAG_BIT];
    end
  end

  // Next value of the event status for the registered interrupt line
  function automatic logic [EV_W_L-1:0] next_ev_status();
    if (REG_WR_I && REG_ADDR_I == pic_pkg::ADR_EV_CLEAR)
      next_ev_status = (ev_status & ~REG_WDATA_I[EV_W_L-1:0]) | ev_set;
    else
      next_ev_status = ev_status | ev_set;
  endfunction

  // Read map; clear register shares the status slot and reads status
  always_comb
  begin
    rd_words[pic_pkg::ADR_IEN_HIGH]  = irq_enable_high_reg;
    rd_words[pic_pkg::ADR_IEN_LOW]   = irq_enable_low_reg;
    rd_words[pic_pkg::ADR_IRQ_HIGH]  = irq_request_high_reg;
    rd_words[pic_pkg::ADR_IRQ_LOW]   = irq_request_low_reg;
    rd_words[pic_pkg::ADR_EDGE_SEL]  = {2'h0, ext_edge_select_reg};
    rd_words[pic_pkg::ADR_PSW]       = processor_status_word;
    rd_words[pic_pkg::ADR_EV_STATUS] = {6'h00, ev_status};
    rd_words[pic_pkg::ADR_EV_ENABLE] = {6'h00, ev_enable};
  end

  pic_regmem u_rd (
    .clk_i  (CLK_I),
    .rst_i  (SYS_RST_I),
    .rd_i   (REG_RD_I),
    .word_i (rd_words),
    .addr_i (REG_ADDR_I),
    .data_o (REG_RDATA_O)
  );

  // Master enable off blocks every new request
  a_iflag_gate: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $rose(CORE_REQ_O) |->
      $past(processor_status_word[pic_pkg::PSW_IFLAG_BIT]))
    else $error("request raised with master enable off");
  // Disabled source never selected
  a_enable_gate: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $rose(CORE_REQ_O) |-> $past(live[win]))
    else $error("request raised for a disabled source");
  // Ack clears master enable
  a_ack_iflag: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (state == pic_pkg::PIC_REQ && CORE_ACK_I) |=>
      !processor_status_word[pic_pkg::PSW_IFLAG_BIT] && !CORE_REQ_O)
    else $error("acknowledge did not drop master enable");
  // Ack clears the served flag unless a new event
  a_ack_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (state == pic_pkg::PIC_REQ && CORE_ACK_I && !src_ev[sel]) |=>
      !irq_req[$past(sel)])
    else $error("served flag not cleared");
  // Timer 0 match event sets its flag next cycle
  a_event_set: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    src_ev[pic_pkg::SRC_TMR0] |=> irq_req[pic_pkg::SRC_TMR0])
    else $error("timer match did not set flag");
  // Wait lasts exactly the acceptance count
  sequence s_wait_full;
    (state == pic_pkg::PIC_WAIT && any_live) [*8];
  endsequence
  a_wait_len: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    ($rose(state == pic_pkg::PIC_WAIT) ##0 s_wait_full) |=>
      state == pic_pkg::PIC_REQ)
    else $error("acceptance latency wrong");
  // Vector matches the held winner
  a_vec_match: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    CORE_REQ_O |-> CORE_VEC_O == vec_of(sel))
    else $error("vector does not match selected source");
  // Flag holds without clear causes
  a_flag_hold: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    (irq_req[pic_pkg::SRC_WT] && !ack_clr[pic_pkg::SRC_WT] &&
     !(REG_WR_I && REG_ADDR_I == pic_pkg::ADR_IRQ_LOW)) |=>
      irq_req[pic_pkg::SRC_WT])
    else $error("request flag dropped on its own");
endmodule

// ### test/pic_core_model.sv
// Behavioural CPU core that takes interrupts from the controller
`timescale 1ns/1ps
module pic_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [15:0] vec_i,
  input  wire logic [3:0]  ack_dly_i,
  output logic             instr_done_o,
  output logic             ack_o,
  output logic      [7:0]  taken_o,
  output logic      [15:0] pc_o,
  output logic      [7:0]  lat_o
);
  logic [3:0] gap;
  logic [7:0] since;
  logic [3:0] hold;
  logic       seen;
  // An instruction ends every 16 cycles, never while a request stands
  always_ff @(posedge clk_i)
  begin
    gap          <= rst_i ? 4'h0 : gap + 4'h1;
    instr_done_o <= !rst_i && gap == 4'hF && !req_i;
  end
  // Cycles from instruction end to request, the acceptance latency
  always_ff @(posedge clk_i)
  begin
    if (rst_i || instr_done_o)
      since <= 8'h00;
    else if (since != 8'hFF)
      since <= since + 8'h01;
    seen <= req_i && !rst_i;
    if (rst_i)
      lat_o <= 8'h00;
    else if (req_i && !seen)
      lat_o <= since + 8'h01;
  end
  // Waits a chosen number of cycles, then acknowledges once
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !req_i || ack_o)
    begin
      hold  <= 4'h0;
      ack_o <= 1'b0;
    end
    else if (hold == ack_dly_i)
      ack_o <= 1'b1;
    else
      hold <= hold + 4'h1;
  end
  // Counts each acceptance and reloads the program counter from the vector on acknowledge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      taken_o <= 8'h00;
      pc_o    <= 16'h0000;
    end
    else if (ack_o)
    begin
      taken_o <= taken_o + 8'h01;
      pc_o    <= vec_i;
    end
  end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [10:0] ev = 11'h000;
  logic [2:0]  pins = 3'h0;
  logic [3:0]  ack_dly = 4'h0;
  logic [7:0]  rdata, taken, lat;
  logic [15:0] vec, pc;
  logic        instr_done, ack, req, iflag, irq;
  logic [31:0] lfsr = 32'h9CCA;
  logic [10:0] mask;
  logic [7:0]  e;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;
  // Free-running 50 MHz clock
  always #10 clk = ~clk;
  pic_top dut (.CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .KEY_EV_I(ev[0]), .BIT_OVF_I(ev[1]), .EXT_PIN_I(pins),
    .TMR0_MATCH_I(ev[4]), .TMR1_MATCH_I(ev[5]), .REM_EV_I(ev[7]),
    .ADC_DONE_I(ev[8]), .SIO_DONE_I(ev[9]), .WT_EV_I(ev[10]),
    .INSTR_DONE_I(instr_done), .CORE_ACK_I(ack), .CORE_REQ_O(req),
    .CORE_VEC_O(vec), .PSW_IFLAG_O(iflag), .IRQ_O(irq));
  pic_core_model core (.clk_i(clk), .rst_i(rst), .req_i(req), .vec_i(vec),
    .ack_dly_i(ack_dly), .instr_done_o(instr_done), .ack_o(ack),
    .taken_o(taken), .pc_o(pc), .lat_o(lat));
  // Cuts a hang short well beyond the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected vector: top address stepping down by priority index
  function automatic logic [15:0] exp_vec(input int i);
    return pic_pkg::VEC_TOP - pic_pkg::VEC_STEP * 16'(i);
  endfunction
  function automatic int top(input logic [10:0] m);
    int t;
    t = 11;
    for (int i = 10; i >= 0; i--)
      if (m[i])
        t = i;
    return t;
  endfunction
  // Bus tasks start just after an edge; a write leaves two idle edges
  // so registered outputs have settled before the caller looks
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] x);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, x)
    @(posedge clk);
  endtask
  task automatic chk_flags(input logic [10:0] m);
    rd_chk(pic_pkg::ADR_IRQ_HIGH, m[7:0]);
    rd_chk(pic_pkg::ADR_IRQ_LOW, {5'h00, m[10:8]});
  endtask
  // One event pulse, or a rising edge on an external pin
  task automatic fire(input int i);
    int p;
    p = (i == 2) ? 0 : (i == 3) ? 1 : (i == 6) ? 2 : 3;
    if (p < 3)
      pins[p] <= 1'b1;
    else
      ev[i] <= 1'b1;
    @(posedge clk);
    pins <= 3'h0;
    ev   <= 11'h000;
    @(posedge clk);
  endtask
  // Waits for the core to take a request and checks what it got
  task automatic accept(input int i);
    int         n;
    logic [7:0] t0;
    n  = 0;
    t0 = taken;
    while (taken === t0 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    `CHK(pc, exp_vec(i))
    `CHK(lat, 8'(pic_pkg::ACCEPT_PERIODS + 1))
    `CHK(iflag, 1'b0)
    `CHK(req, 1'b0)
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(vec, pic_pkg::VEC_RESET)
    for (int a = 0; a < 8; a++)
      rd_chk(3'(a), 8'h00);
    // Each source alone: vector, latency, flag cleared on acceptance
    wr_reg(pic_pkg::ADR_EDGE_SEL, 8'h2A);
    wr_reg(pic_pkg::ADR_IEN_HIGH, 8'hFF);
    wr_reg(pic_pkg::ADR_IEN_LOW, 8'h07);
    for (int i = 0; i < 11; i++)
    begin
      lfsr = lfsr_next(lfsr);
      ack_dly <= lfsr[3:0];
      wr_reg(pic_pkg::ADR_PSW, 8'h04);
      `CHK(iflag, 1'b1)
      fire(i);
      accept(i);
      chk_flags(11'h000);
    end
    // Random pairs held off by the master enable, then served in order
    repeat (6)
    begin
      lfsr = lfsr_next(lfsr);
      mask = 11'h000;
      mask[lfsr[7:4] % 11] = 1'b1;
      mask[lfsr[15:12] % 11] = 1'b1;
      fire(lfsr[7:4] % 11);
      fire(lfsr[15:12] % 11);
      repeat (40) @(posedge clk);
      `CHK(req, 1'b0)
      chk_flags(mask);
      while (mask != 11'h000)
      begin
        wr_reg(pic_pkg::ADR_PSW, 8'h04);
        accept(top(mask));
        mask[top(mask)] = 1'b0;
        chk_flags(mask);
      end
    end
    // Disabled source stays pending; software clears and sets flags
    wr_reg(pic_pkg::ADR_IEN_HIGH, 8'h00);
    wr_reg(pic_pkg::ADR_IEN_LOW, 8'h00);
    wr_reg(pic_pkg::ADR_EV_CLEAR, 8'h03);
    wr_reg(pic_pkg::ADR_EV_ENABLE, 8'h01);
    wr_reg(pic_pkg::ADR_PSW, 8'h04);
    fire(4);
    repeat (40) @(posedge clk);
    `CHK(req, 1'b0)
    chk_flags(11'h010);
    wr_reg(pic_pkg::ADR_IRQ_HIGH, 8'h00);
    chk_flags(11'h000);
    wr_reg(pic_pkg::ADR_IRQ_LOW, 8'h04);
    chk_flags(11'h400);
    `CHK(irq, 1'b0)
    wr_reg(pic_pkg::ADR_IEN_LOW, 8'h04);
    accept(10);
    `CHK(irq, 1'b1)
    rd_chk(pic_pkg::ADR_EV_STATUS, 8'h01);
    wr_reg(pic_pkg::ADR_EV_ENABLE, 8'h00);
    `CHK(irq, 1'b0)
    wr_reg(pic_pkg::ADR_EV_ENABLE, 8'h01);
    `CHK(irq, 1'b1)
    wr_reg(pic_pkg::ADR_EV_CLEAR, 8'h01);
    `CHK(irq, 1'b0)
    rd_chk(pic_pkg::ADR_EV_STATUS, 8'h00);
    // Every edge mode on every pin, rise then fall
    for (int p = 0; p < 3; p++)
      for (int m = 0; m < 4; m++)
      begin
        wr_reg(pic_pkg::ADR_EDGE_SEL, 8'(m) << (2 * p));
        wr_reg(pic_pkg::ADR_IRQ_HIGH, 8'h00);
        pins[p] <= 1'b1;
        repeat (3) @(posedge clk);
        e = (m[1] == 1'b1) ? 8'h01 << ((p == 2) ? 6 : p + 2) : 8'h00;
        rd_chk(pic_pkg::ADR_IRQ_HIGH, e);
        pins[p] <= 1'b0;
        repeat (3) @(posedge clk);
        if (m[0] == 1'b1)
          e = 8'h01 << ((p == 2) ? 6 : p + 2);
        rd_chk(pic_pkg::ADR_IRQ_HIGH, e);
      end
    // Register readback and the edge event left by the pin walk
    rd_chk(pic_pkg::ADR_EDGE_SEL, 8'h30);
    rd_chk(pic_pkg::ADR_IEN_LOW, 8'h04);
    rd_chk(pic_pkg::ADR_PSW, 8'h00);
    rd_chk(pic_pkg::ADR_EV_ENABLE, 8'h01);
    rd_chk(pic_pkg::ADR_EV_STATUS, 8'h02);
    `CHK(irq, 1'b0)
    tally_and_finish();
  end
endmodule
